//--- iox_expander.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// serial engine, runs on the bus clock
// ------------------------------------------------------------
module iox_link (
	// bus clock and data pin
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_oe,
	// crossing to the register core
	iox_link_if.link lk
);
	iox_pkg::iox_lstate_t state_r;
	logic [3:0] cnt_r;
	logic [6:0] shift_r;
	logic ack_r;
	logic [7:0] byte_c;
	logic addr_hit_c;
	logic fire_c;
	iox_pkg::iox_ev_t kind_c;

	// byte completed by the bit on the line now
	always_comb begin
		byte_c = {shift_r, sda_in};
	end

	// own address, general call excluded
	always_comb begin
		addr_hit_c = (byte_c[7:1] == {iox_pkg::ADDR_FIXED, lk.strap}) &&
			(byte_c[7:1] != iox_pkg::GEN_CALL_ADDR);
	end

	// which event the core must see
	always_comb begin
		fire_c = 1'b0;
		kind_c = iox_pkg::EV_CMD;
		if (cnt_r == iox_pkg::BIT_LAST) begin
			case (state_r)
				iox_pkg::LS_ADDR: begin
					if (addr_hit_c && byte_c[0]) begin
						fire_c = 1'b1;
						kind_c = iox_pkg::EV_RDADDR;
					end
				end
				iox_pkg::LS_CMD: begin
					fire_c = 1'b1;
					kind_c = iox_pkg::EV_CMD;
				end
				iox_pkg::LS_WDATA: begin
					fire_c = 1'b1;
					kind_c = iox_pkg::EV_WR;
				end
				default: begin
					fire_c = 1'b0;
				end
			endcase
		end else if (cnt_r == iox_pkg::BIT_ACK && state_r == iox_pkg::LS_RDATA && !ack_r) begin
			// master ack or nack of a read byte
			fire_c = 1'b1;
			kind_c = iox_pkg::EV_RDACK;
		end
	end

	// bit engine, sampling on rising clock
	always_ff @(posedge scl or posedge lk.clr) begin
		if (lk.clr) begin
			state_r <= iox_pkg::LS_ADDR;
			cnt_r <= 4'h0;
			shift_r <= 7'h00;
			ack_r <= 1'b0;
		end else if (cnt_r == iox_pkg::BIT_ACK) begin
			cnt_r <= 4'h0;
			if (state_r == iox_pkg::LS_RDATA && !ack_r && sda_in) begin
				state_r <= iox_pkg::LS_IDLE;
			end
		end else begin
			cnt_r <= 4'(cnt_r + 4'h1);
			shift_r <= byte_c[6:0];
			if (cnt_r == iox_pkg::BIT_LAST) begin
				case (state_r)
					iox_pkg::LS_ADDR: begin
						ack_r <= addr_hit_c;
						if (!addr_hit_c) begin
							state_r <= iox_pkg::LS_IDLE;
						end else if (byte_c[0]) begin
							state_r <= iox_pkg::LS_RDATA;
						end else begin
							state_r <= iox_pkg::LS_CMD;
						end
					end
					iox_pkg::LS_CMD: begin
						ack_r <= 1'b1;
						state_r <= iox_pkg::LS_WDATA;
					end
					iox_pkg::LS_WDATA: begin
						ack_r <= 1'b1;
					end
					default: begin
						ack_r <= 1'b0;
					end
				endcase
			end
		end
	end

	// event toggle and its payload toward the core
	always_ff @(posedge scl or posedge lk.hard_rst) begin
		if (lk.hard_rst) begin
			lk.ev_tgl <= 1'b0;
			lk.ev_kind <= iox_pkg::EV_CMD;
			lk.ev_byte <= 8'h00;
		end else if (fire_c) begin
			lk.ev_tgl <= ~lk.ev_tgl;
			lk.ev_kind <= kind_c;
			lk.ev_byte <= byte_c;
		end
	end

	// line driver, changes on falling clock or on clear
	always_ff @(negedge scl or posedge lk.clr) begin
		if (lk.clr) begin
			sda_oe <= 1'b0;
		end else if (cnt_r == iox_pkg::BIT_ACK) begin
			sda_oe <= ack_r;
		end else if (state_r == iox_pkg::LS_RDATA) begin
			// pull low for a zero, msb first
			sda_oe <= ~lk.tx_byte[3'(iox_pkg::BIT_LAST - cnt_r)];
		end else begin
			sda_oe <= 1'b0;
		end
	end
endmodule

// ------------------------------------------------------------
// expander top, register core on the system clock
// ------------------------------------------------------------
module iox_expander (
	// system
	input wire logic sys_clk,
	input wire logic reset,
	// reset pin
	input wire logic reset_pin_n,
	// serial bus
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// address straps
	input wire logic strap_addr_bit0,
	input wire logic strap_addr_bit1,
	// port pins
	input wire logic [7:0] bank0_pins_in,
	output logic [7:0] bank0_pins_out,
	output logic [7:0] bank0_pins_oe,
	input wire logic [7:0] bank1_pins_in,
	output logic [7:0] bank1_pins_out,
	output logic [7:0] bank1_pins_oe,
	// interrupt pin, open drain
	output logic alert_n_out,
	output logic alert_n_oe
);
	localparam int SYNC_W = 22;
	localparam int CLR_CNT_W = $clog2(iox_pkg::CLEAR_PULSE_CYC + 1);
	localparam logic [CLR_CNT_W-1:0] CLR_CYC = CLR_CNT_W'(iox_pkg::CLEAR_PULSE_CYC);

	iox_link_if lk ();

	logic [SYNC_W-1:0] raw_c;
	logic [SYNC_W-1:0] syn_c;
	logic tgl_s, scl_s, sda_s, rstn_s;
	logic [1:0] strap_s;
	logic [15:0] pins_s;
	logic [CLR_CNT_W-1:0] low_cnt_r;
	logic pin_rst_r;
	logic rst_c;
	logic scl_d_r, sda_d_r;
	logic start_c, stop_c;
	logic clr_r, start_hold_r, hard_rst_r;
	logic ev_seen_r;
	logic ev_new_c;
	logic [7:0] ptr_r;
	logic [2:0] sel_c;
	logic [7:0] tx_r;
	logic [15:0] out_r, pol_r, cfg_r;
	logic [15:0] in_lvl_c;
	logic [15:0] snap_r;
	logic [1:0] ref_fill_r;
	logic [15:0] diff_c;

	// ------------------------------------------------------------
	// synchronisers and reset
	// ------------------------------------------------------------
	// every foreign level but the event kind and byte enters through two flops
	always_comb begin
		raw_c = {lk.ev_tgl, scl, sda_in, reset_pin_n, strap_addr_bit1, strap_addr_bit0,
			bank1_pins_in, bank0_pins_in};
	end

	iox_sync #(.W(SYNC_W)) u_sync (
		.clk(sys_clk),
		.d(raw_c),
		.q(syn_c)
	);

	assign {tgl_s, scl_s, sda_s, rstn_s, strap_s, pins_s} = syn_c;

	// reset pin counts as reset once low long enough
	always_ff @(posedge sys_clk) begin
		if (reset || rstn_s) begin
			low_cnt_r <= '0;
			pin_rst_r <= 1'b0;
		end else begin
			if (low_cnt_r != CLR_CYC) begin
				low_cnt_r <= CLR_CNT_W'(low_cnt_r + 1'b1);
			end
			pin_rst_r <= (low_cnt_r == CLR_CYC);
		end
	end

	// power-on reset and pin reset act alike
	assign rst_c = reset | pin_rst_r;

	// ------------------------------------------------------------
	// start and stop detection
	// ------------------------------------------------------------
	// previous bus levels
	always_ff @(posedge sys_clk) begin
		scl_d_r <= scl_s;
		sda_d_r <= sda_s;
	end

	// data edge while clock high is a condition, not data
	assign start_c = scl_s & scl_d_r & sda_d_r & ~sda_s;
	assign stop_c = scl_s & scl_d_r & ~sda_d_r & sda_s;

	// engine held clear outside frames, freed after start once clock is low
	always_ff @(posedge sys_clk) begin
		if (rst_c) begin
			clr_r <= 1'b1;
			start_hold_r <= 1'b0;
		end else if (start_c) begin
			clr_r <= 1'b1;
			start_hold_r <= 1'b1;
		end else if (stop_c) begin
			clr_r <= 1'b1;
			start_hold_r <= 1'b0;
		end else if (start_hold_r && !scl_s) begin
			clr_r <= 1'b0;
			start_hold_r <= 1'b0;
		end
	end

	// registered reset for the bus-clock side
	always_ff @(posedge sys_clk) begin
		hard_rst_r <= rst_c;
	end

	assign lk.clr = clr_r;
	assign lk.hard_rst = hard_rst_r;
	assign lk.strap = strap_s;
	assign lk.tx_byte = tx_r;

	iox_link u_link (
		.scl(scl),
		.sda_in(sda_in),
		.sda_oe(sda_oe),
		.lk(lk)
	);

	// ------------------------------------------------------------
	// events from the serial engine
	// ------------------------------------------------------------
	// payload is steady for a whole byte after the toggle moves
	always_ff @(posedge sys_clk) begin
		if (rst_c) begin
			ev_seen_r <= tgl_s;
		end else begin
			ev_seen_r <= tgl_s;
		end
	end

	assign ev_new_c = (tgl_s ^ ev_seen_r) & ~rst_c;
	assign sel_c = ptr_r[iox_pkg::SEL_MSB:0];

	// input level as read, polarity applied
	assign in_lvl_c = pins_s ^ pol_r;

	// value of a selected register
	function automatic logic [7:0] reg_val(input logic [2:0] s);
		logic [15:0] v;
		case (s[2:1])
			iox_pkg::GRP_IN: v = in_lvl_c;
			iox_pkg::GRP_OUT: v = out_r;
			iox_pkg::GRP_POL: v = pol_r;
			default: v = cfg_r;
		endcase
		return s[0] ? v[15:8] : v[7:0];
	endfunction

	// register pointer
	always_ff @(posedge sys_clk) begin
		if (rst_c) begin
			ptr_r <= iox_pkg::PTR_RST;
		end else if (ev_new_c) begin
			case (lk.ev_kind)
				iox_pkg::EV_CMD: ptr_r <= lk.ev_byte;
				iox_pkg::EV_WR: ptr_r[0] <= ~ptr_r[0];
				iox_pkg::EV_RDACK: ptr_r[0] <= ~ptr_r[0];
				default: ptr_r <= ptr_r;
			endcase
		end
	end

	// writable register pairs
	always_ff @(posedge sys_clk) begin
		if (rst_c) begin
			out_r <= {2{iox_pkg::OUT_RST}};
			pol_r <= {2{iox_pkg::POL_RST}};
			cfg_r <= {2{iox_pkg::CFG_RST}};
		end else if (ev_new_c && lk.ev_kind == iox_pkg::EV_WR) begin
			case (sel_c[2:1])
				iox_pkg::GRP_OUT: begin
					out_r <= sel_c[0] ? {lk.ev_byte, out_r[7:0]} : {out_r[15:8], lk.ev_byte};
				end
				iox_pkg::GRP_POL: begin
					pol_r <= sel_c[0] ? {lk.ev_byte, pol_r[7:0]} : {pol_r[15:8], lk.ev_byte};
				end
				iox_pkg::GRP_CFG: begin
					cfg_r <= sel_c[0] ? {lk.ev_byte, cfg_r[7:0]} : {cfg_r[15:8], lk.ev_byte};
				end
				default: begin
					out_r <= out_r;
				end
			endcase
		end
	end

	// byte handed to the engine for the next read slot
	always_ff @(posedge sys_clk) begin
		if (rst_c) begin
			tx_r <= 8'h00;
		end else if (ev_new_c && lk.ev_kind == iox_pkg::EV_RDADDR) begin
			tx_r <= reg_val(sel_c);
		end else if (ev_new_c && lk.ev_kind == iox_pkg::EV_RDACK) begin
			tx_r <= reg_val({sel_c[2:1], ~sel_c[0]});
		end
	end

	// ------------------------------------------------------------
	// change detection
	// ------------------------------------------------------------
	// reference levels, follow the pins until the synchronisers hold real levels
	always_ff @(posedge sys_clk) begin
		if (rst_c) begin
			snap_r <= 16'h0000;
			ref_fill_r <= iox_pkg::REF_FILL_CYC;
		end else if (ref_fill_r != 2'h0) begin
			snap_r <= in_lvl_c;
			ref_fill_r <= 2'(ref_fill_r - 2'h1);
		end else if (ev_new_c && lk.ev_kind == iox_pkg::EV_RDACK &&
			sel_c[2:1] == iox_pkg::GRP_IN) begin
			// load what was sent, so a later change still alerts
			if (sel_c[0]) begin
				snap_r[15:8] <= tx_r;
			end else begin
				snap_r[7:0] <= tx_r;
			end
		end
	end

	// only input-configured bits may differ
	assign diff_c = (in_lvl_c ^ snap_r) & cfg_r;

	// alert pulls low while any bank differs
	always_ff @(posedge sys_clk) begin
		if (rst_c) begin
			alert_n_oe <= 1'b0;
		end else begin
			alert_n_oe <= (ref_fill_r == 2'h0) & (|diff_c);
		end
	end

	// ------------------------------------------------------------
	// pin drivers
	// ------------------------------------------------------------
	// direction and level per pin
	always_ff @(posedge sys_clk) begin
		if (rst_c) begin
			bank0_pins_out <= iox_pkg::OUT_RST;
			bank1_pins_out <= iox_pkg::OUT_RST;
			bank0_pins_oe <= 8'h00;
			bank1_pins_oe <= 8'h00;
		end else begin
			bank0_pins_out <= out_r[7:0];
			bank1_pins_out <= out_r[15:8];
			bank0_pins_oe <= ~cfg_r[7:0];
			bank1_pins_oe <= ~cfg_r[15:8];
		end
	end

	// open-drain lines only ever pull low
	always_ff @(posedge sys_clk) begin
		if (rst_c) begin
			sda_out <= 1'b0;
			alert_n_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
			alert_n_out <= 1'b0;
		end
	end
endmodule

//--- iox_link_if.sv
`timescale 1ns/1ps
interface iox_link_if;
	// core to link
	logic clr;
	logic hard_rst;
	logic [1:0] strap;
	logic [7:0] tx_byte;
	// link to core
	logic ev_tgl;
	iox_pkg::iox_ev_t ev_kind;
	logic [7:0] ev_byte;

	modport link (
		input clr, hard_rst, strap, tx_byte,
		output ev_tgl, ev_kind, ev_byte
	);
	modport core (
		output clr, hard_rst, strap, tx_byte,
		input ev_tgl, ev_kind, ev_byte
	);
endinterface

//--- iox_monitor.sv
`timescale 1ns/1ps
// pin level checker for the expander top
module iox_monitor (
	// system
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic reset_pin_n,
	// serial bus
	input wire logic scl,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	// port pins
	input wire logic [7:0] bank0_pins_in,
	input wire logic [7:0] bank0_pins_out,
	input wire logic [7:0] bank0_pins_oe,
	input wire logic [7:0] bank1_pins_in,
	input wire logic [7:0] bank1_pins_out,
	input wire logic [7:0] bank1_pins_oe,
	// interrupt pin
	input wire logic alert_n_out,
	input wire logic alert_n_oe
);
	logic scl_d_r;
	logic [7:0] since_rise_r;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	// system cycles since the last bus clock rise, saturating
	always_ff @(posedge sys_clk) begin
		scl_d_r <= scl;
		if (reset) begin
			since_rise_r <= 8'hff;
		end else if (scl && !scl_d_r) begin
			since_rise_r <= 8'h00;
		end else if (since_rise_r != 8'hff) begin
			since_rise_r <= since_rise_r + 8'h01;
		end
	end
	// reset levels and open-drain drive
	reset_defaults_a: assert property (disable iff (1'b0) reset |=> bank0_pins_oe == 8'h00
		&& bank1_pins_oe == 8'h00 && bank0_pins_out == 8'hff && !alert_n_oe)
		else $error("outputs not at defaults under reset");
	pin_reset_a: assert property (!reset_pin_n [*8] |-> bank0_pins_oe == 8'h00
		&& bank1_pins_oe == 8'h00 && bank1_pins_out == 8'hff && !alert_n_oe)
		else $error("reset pin did not restore defaults");
	drive_low_a: assert property (!sda_out && !alert_n_out)
		else $error("open drain pin driven high");
	// bus timing of the data line
	sda_move_a: assert property ($changed(sda_oe) |-> !scl)
		else $error("data drive moved while clock high");
	sda_steady_a: assert property (scl && $past(scl) |-> $stable(sda_oe))
		else $error("data drive changed while clock high");
	ack_rise_a: assert property ($rose(sda_oe) |-> !scl)
		else $error("data drive started outside clock low");
	// alert and register side effects
	quiet_alert_a: assert property ((scl && sda_in && reset_pin_n && since_rise_r > 8'h10
		&& $stable(bank0_pins_in) && $stable(bank1_pins_in)) [*8] |=> $stable(alert_n_oe))
		else $error("alert moved with pins and bus quiet");
	write_timing_a: assert property ($changed({bank0_pins_out, bank1_pins_out, bank0_pins_oe,
		bank1_pins_oe}) && reset_pin_n |-> since_rise_r < 8'h0c)
		else $error("pin outputs changed away from a bus bit");
	cover property ($rose(alert_n_oe));
	cover property ($rose(sda_oe));
	cover property ($changed(bank0_pins_oe));
endmodule
bind iox_expander iox_monitor u_mon (.sys_clk(sys_clk), .reset(reset),
	.reset_pin_n(reset_pin_n), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.bank0_pins_in(bank0_pins_in), .bank0_pins_out(bank0_pins_out), .bank0_pins_oe(bank0_pins_oe),
	.bank1_pins_in(bank1_pins_in), .bank1_pins_out(bank1_pins_out), .bank1_pins_oe(bank1_pins_oe),
	.alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe));

//--- iox_mst.sv
`timescale 1ns/1ps
// serial bus master, clock stands high between frames
module iox_mst (
	// bus
	output logic scl,
	output logic sda_pull,
	input wire logic sda
);
	// idle bus
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	// one bit, data moved only while clock low, long high for ack slots
	task automatic bit_x(input logic b, output logic s, input int hi);
		sda_pull = ~b;
		#8 scl = 1'b1;
		#7 s = sda;
		#(8 + hi) scl = 1'b0;
		#7;
	endtask
	// start or repeated start
	task automatic start_c();
		sda_pull = 1'b0;
		#8 scl = 1'b1;
		#20 sda_pull = 1'b1;
		#20 scl = 1'b0;
		#12; // long low lets the engine leave its cleared state first
	endtask
	// stop, then bus free
	task automatic stop_c();
		sda_pull = 1'b1;
		#8 scl = 1'b1;
		#20 sda_pull = 1'b0;
		#40;
	endtask
	// byte out msb first, line released for the ack
	task automatic put_byte(input logic [7:0] b, output logic nak);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_x(b[i], s, 0);
		end
		bit_x(1'b1, nak, 600);
	endtask
	// byte in, then ack or nack
	task automatic get_byte(output logic [7:0] b, input logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, b[i], 0);
		end
		bit_x(~ack, s, 600);
	endtask
endmodule

//--- iox_pkg.sv
package iox_pkg;

	// ------------------------------------------------------------
	// device address
	// ------------------------------------------------------------
	// upper five address bits; the two straps fill the low bits
	localparam logic [4:0] ADDR_FIXED = 5'h1d;
	localparam logic [6:0] GEN_CALL_ADDR = 7'h00;

	// ------------------------------------------------------------
	// command byte and register selection
	// ------------------------------------------------------------
	localparam int SEL_MSB = 2;
	localparam logic [2:0] REG_IN0 = 3'h0;
	localparam logic [2:0] REG_OUT0 = 3'h2;
	localparam logic [2:0] REG_POL0 = 3'h4;
	localparam logic [2:0] REG_CFG0 = 3'h6;
	// pair group of a register, the low select bit picks the bank
	localparam logic [1:0] GRP_IN = REG_IN0[2:1];
	localparam logic [1:0] GRP_OUT = REG_OUT0[2:1];
	localparam logic [1:0] GRP_POL = REG_POL0[2:1];
	localparam logic [1:0] GRP_CFG = REG_CFG0[2:1];

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] PTR_RST = 8'h00;
	localparam logic [7:0] OUT_RST = 8'hff;
	localparam logic [7:0] POL_RST = 8'h00;
	localparam logic [7:0] CFG_RST = 8'hff;

	// ------------------------------------------------------------
	// bit positions within a byte slot
	// ------------------------------------------------------------
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int SYS_CLK_MHZ = 250;
	localparam int CLEAR_PULSE_MIN_NS = 6;
	localparam int CLEAR_PULSE_CYC = (CLEAR_PULSE_MIN_NS * SYS_CLK_MHZ + 999) / 1000;
	// cycles the reference follows the pins after reset, covers synchroniser fill
	localparam logic [1:0] REF_FILL_CYC = 2'h3;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {EV_CMD, EV_WR, EV_RDADDR, EV_RDACK} iox_ev_t;
	typedef enum logic [2:0] {LS_ADDR, LS_CMD, LS_WDATA, LS_RDATA, LS_IDLE} iox_lstate_t;

endpackage

//--- iox_sync.sv
`timescale 1ns/1ps
module iox_sync #(
	parameter int W = 1
) (
	// clock
	input wire logic clk,
	// levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// refuse an empty vector
	if (W < 1) begin : g_chk
		$error("iox_sync width must be at least one");
	end

	// two-stage synchroniser, first stage feeds only the second
	always_ff @(posedge clk) begin
		meta_r <= d;
		q <= meta_r;
	end
endmodule

//--- test_i2c_sixteen_bit_io_expander.sv
`timescale 1ns/1ps
// self-checking bench for the io expander
module test_i2c_sixteen_bit_io_expander;
	logic sys_clk;
	logic reset;
	logic reset_pin_n;
	logic strap0;
	logic strap1;
	logic [7:0] ext0;
	logic [7:0] ext1;
	logic scl;
	logic mst_pull;
	logic sda_out;
	logic sda_oe;
	logic [7:0] out0, oe0, out1, oe1;
	logic alert_n_out;
	logic alert_n_oe;
	logic [6:0] dev;
	logic [7:0] r0, r1;
	logic nak;
	logic [7:0] dflt [4] = '{8'h00, 8'hff, 8'h00, 8'hff};
	int bad_count;
	int checked;
	// pulled-up data line and pin levels
	wire sda = ~(mst_pull | sda_oe);
	wire [7:0] pin0 = (oe0 & out0) | (~oe0 & ext0);
	wire [7:0] pin1 = (oe1 & out1) | (~oe1 & ext1);
	// system clock
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	iox_expander u_dut (.sys_clk(sys_clk), .reset(reset), .reset_pin_n(reset_pin_n),
		.scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.strap_addr_bit0(strap0), .strap_addr_bit1(strap1),
		.bank0_pins_in(pin0), .bank0_pins_out(out0), .bank0_pins_oe(oe0),
		.bank1_pins_in(pin1), .bank1_pins_out(out1), .bank1_pins_oe(oe1),
		.alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe));
	iox_mst u_mst (.scl(scl), .sda_pull(mst_pull), .sda(sda));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic alert_is(input logic e);
		check({7'h00, alert_n_oe}, {7'h00, e});
	endtask
	task automatic settle();
		repeat (8) @(negedge sys_clk);
	endtask
	// command then a register pair
	task automatic reg_write(input logic [7:0] cmd, input logic [7:0] d0, input logic [7:0] d1);
		u_mst.start_c();
		u_mst.put_byte({dev, 1'b0}, nak);
		check({7'h00, nak}, 8'h00);
		u_mst.put_byte(cmd, nak);
		u_mst.put_byte(d0, nak);
		u_mst.put_byte(d1, nak);
		check({7'h00, nak}, 8'h00);
		u_mst.stop_c();
		settle();
	endtask
	// pointer only, frame left open
	task automatic set_ptr(input logic [7:0] cmd);
		u_mst.start_c();
		u_mst.put_byte({dev, 1'b0}, nak);
		u_mst.put_byte(cmd, nak);
		check({7'h00, nak}, 8'h00);
	endtask
	// read frame of one or two bytes
	task automatic rd_frame(input int n);
		u_mst.start_c();
		u_mst.put_byte({dev, 1'b1}, nak);
		check({7'h00, nak}, 8'h00);
		u_mst.get_byte(r0, n == 2);
		if (n == 2) begin
			u_mst.get_byte(r1, 1'b0);
		end
		check({7'h00, sda_oe}, 8'h00);
		u_mst.stop_c();
		settle();
	endtask
	// address that must not be answered
	task automatic refused(input logic [7:0] a);
		u_mst.start_c();
		u_mst.put_byte(a, nak);
		check({7'h00, nak}, 8'h01);
		u_mst.stop_c();
		settle();
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d, mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// hang guard
	initial begin
		#300000;
		bad_count++;
		tally_and_finish();
	end
	// test sequence
	initial begin
		bad_count = 0;
		checked = 0;
		reset = 1'b1;
		reset_pin_n = 1'b1;
		strap0 = 1'b1;
		strap1 = 1'b0;
		ext0 = 8'h00;
		ext1 = 8'h00;
		dev = 7'h75;
		repeat (2) @(negedge sys_clk);
		reset = 1'b0;
		settle();
		check(oe0, 8'h00);
		check(out1, 8'hff);
		for (int k = 1; k < 4; k++) begin
			set_ptr({5'h00, k[1:0], 1'b0});
			rd_frame(2);
			check(r0, dflt[k]);
			check(r1, dflt[k]);
		end
		set_ptr(8'h00);
		rd_frame(2);
		check(r0, 8'h00);
		ext0 = 8'h81;
		settle();
		alert_is(1'b1);
		ext0 = 8'h00;
		settle();
		alert_is(1'b0);
		ext0 = 8'h80;
		settle();
		set_ptr(8'h01);
		rd_frame(1);
		alert_is(1'b1);
		set_ptr(8'h00);
		rd_frame(1);
		check(r0, 8'h80);
		alert_is(1'b0);
		ext0 = 8'h00;
		settle();
		set_ptr(8'h02);
		refused(8'he9);
		refused(8'h00);
		alert_is(1'b1);
		strap0 = 1'b0;
		strap1 = 1'b1;
		dev = 7'h76;
		settle();
		set_ptr(8'h00);
		rd_frame(1);
		alert_is(1'b0);
		reg_write(8'h02, 8'ha5, 8'h3c);
		reg_write(8'h07, 8'h0f, 8'hf0);
		check(oe0, 8'h0f);
		check(oe1, 8'hf0);
		check(out0, 8'ha5);
		set_ptr(8'h03);
		rd_frame(2);
		check(r1, 8'ha5);
		rd_frame(1);
		check(r0, 8'h3c);
		reg_write(8'h02, 8'h5a, 8'h3c);
		alert_is(1'b0);
		reg_write(8'h00, 8'h55, 8'h55);
		reg_write(8'h04, 8'hf0, 8'h00);
		set_ptr(8'h00);
		rd_frame(2);
		check(r0, 8'hfa);
		check(r1, 8'h30);
		reg_write(8'h04, 8'h00, 8'h00);
		set_ptr(8'h00);
		rd_frame(2);
		reg_write(8'h06, 8'hf0, 8'hff);
		check(oe1, 8'h00);
		alert_is(1'b1);
		reset_pin_n = 1'b0;
		repeat (12) @(negedge sys_clk);
		reset_pin_n = 1'b1;
		settle();
		check(oe0, 8'h00);
		check(out0, 8'hff);
		alert_is(1'b0);
		rd_frame(1);
		check(r0, 8'h00);
		tally_and_finish();
	end
endmodule
